// *** core/fdt_pkg.sv ***
package fdt_pkg;
  // register byte offsets, one aligned word each
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_FIRST_KEY = 8'h04;
  localparam logic [7:0] OFF_SECOND_KEY = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0C;
  localparam logic [7:0] OFF_CNT_LOW   = 8'h10;
  localparam logic [7:0] OFF_CNT_HIGH  = 8'h14;
  localparam logic [7:0] OFF_CFG_LOW   = 8'h18;
  localparam logic [7:0] OFF_CFG_HIGH  = 8'h1C;
  localparam logic [7:0] OFF_SNAPSHOT  = 8'h20;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h24;
  localparam logic [7:0] OFF_IRQ_CLR   = 8'h28;
  localparam logic [7:0] OFF_IRQ_EN    = 8'h2C;

  // field positions
  localparam int CTRL_ON_BIT    = 15;
  localparam int ST_WINDOW_BIT  = 0;
  localparam int ST_EVENT_BIT   = 5;
  localparam int ST_SECOND_KEY_ERROR_FLAG_BIT    = 6;
  localparam int ST_FIRST_KEY_ERROR_FLAG_BIT    = 7;
  localparam int IRQ_EVENT_BIT  = 0;
  localparam int IRQ_FIRST_KEY_ERROR_FLAG_BIT   = 1;
  localparam int IRQ_SECOND_KEY_ERROR_FLAG_BIT   = 2;
  localparam int IRQ_W          = 3;

  // key patterns and reset values
  localparam logic [7:0]  FIRST_KEY_OK  = 8'h40;
  localparam logic [7:0]  SECOND_KEY_OK = 8'h08;
  localparam logic [15:0] HALF_ZERO     = 16'h0000;
  localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;
  localparam logic [31:0] COUNT_ONE     = 32'h0000_0001;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // static configuration fuse word
  typedef struct packed {
    logic        force_on;
    logic        timer_disable;
    logic [15:0] count_high;
    logic [15:0] count_low;
  } fdt_fuse_t;

  // the three sticky key/event flags
  typedef struct packed {
    logic first_key_error_flag;
    logic second_key_error_flag;
    logic event_f;
  } fdt_flags_t;
endpackage

// *** core/fdt_top.sv ***
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Contract
// RULE_01 - counter steps once per instruction fetch, stops on match
// RULE_02 - 32-bit counter, match value from two 16-bit fuse halves
// RULE_03 - enabled by fuse, or control bit 15 when fuse disable is zero
// RULE_04 - first key must be 0x40 in bits 15:8, else first-key error
// RULE_05 - second key 0x08 after good first key clears keys, restarts count
// RULE_06 - bad second key sets error, keeps first key, captures value
// RULE_07 - good sequence clears both key fields
// RULE_08 - status bit 0 shows clear window open
// RULE_09 - event flag sets on expiry or on bad key before an increment
// RULE_10 - error and event flags sticky until device reset
// RULE_11 - deadman event raises processor interrupt
// RULE_12 - count readable as two read-only halves, reset zero
// RULE_13 - low config mirror shows low fuse count
// RULE_14 - snapshot takes upper count only when count is read
// RULE_15 - high config mirror shows high fuse count
// RULE_16 - event interrupt held until reset, counter stays at match
module fdt_top (
  // clock and reset
  input  wire logic              SYS_CLK_I,
  input  wire logic              SYS_RST_I,
  // processor core
  input  wire logic              FETCH_I,
  output logic                   DEADMAN_IRQ_O,
  // configuration fuses, static
  input  wire fdt_pkg::fdt_fuse_t FUSE_I,
  // AXI4-Lite write address and data
  input  wire logic [7:0]        AWADDR_I,
  input  wire logic              AWVALID_I,
  output logic                   AWREADY_O,
  input  wire logic [31:0]       WDATA_I,
  input  wire logic [3:0]        WSTRB_I,
  input  wire logic              WVALID_I,
  output logic                   WREADY_O,
  // AXI4-Lite write response
  output logic [1:0]             BRESP_O,
  output logic                   BVALID_O,
  input  wire logic              BREADY_I,
  // AXI4-Lite read
  input  wire logic [7:0]        ARADDR_I,
  input  wire logic              ARVALID_I,
  output logic                   ARREADY_O,
  output logic [31:0]            RDATA_O,
  output logic [1:0]             RRESP_O,
  output logic                   RVALID_O,
  input  wire logic              RREADY_I,
  // masked status interrupt
  output logic                   IRQ_O
);

  // bus slave state
  logic        aw_full_r, aw_full_nxt;
  logic [7:0]  aw_addr_r, aw_addr_nxt;
  logic        w_full_r, w_full_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0]  w_strb_r, w_strb_nxt;
  logic        awready_r, awready_nxt;
  logic        wready_r, wready_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        arready_r, arready_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;

  // timer state
  logic                on_r, on_nxt;
  logic [7:0]          first_r, first_nxt;
  logic [7:0]          second_r, second_nxt;
  logic [31:0]         cnt_r, cnt_nxt;
  logic [15:0]         snap_r, snap_nxt;
  fdt_pkg::fdt_flags_t flags_r, flags_nxt;
  logic [2:0]          ist_r, ist_nxt;
  logic [2:0]          ien_r, ien_nxt;
  logic                irq_r, irq_nxt;

  // helpers
  logic        do_wr;
  logic        do_rd;
  logic        active;
  logic        matched;
  logic        window;
  logic        wr_mapped;
  logic [2:0]  iev;
  logic [2:0]  iclr;
  logic        first_key_error_flag_ev, second_key_error_flag_ev, exp_ev, good_seq;
  logic [31:0] match_val;

  // fuse enable wins; the soft bit counts only without fuse disable
  assign active    = FUSE_I.force_on |
                     (~FUSE_I.timer_disable & on_r);  // RULE_03
  assign match_val = {FUSE_I.count_high, FUSE_I.count_low}; // RULE_02
  assign matched   = (cnt_r == match_val);
  // window is open once a good first key waits for its partner
  assign window    = active & (first_r == fdt_pkg::FIRST_KEY_OK)
                     & ~flags_r.event_f;
  assign do_wr     = aw_full_r & w_full_r & ~bvalid_r;
  assign do_rd     = ARVALID_I & arready_r;

  // register write side effects, key sequence and counter
  always_comb begin
    on_nxt    = on_r;
    first_nxt = first_r;
    second_nxt = second_r;
    cnt_nxt   = cnt_r;
    flags_nxt = flags_r;
    ien_nxt   = ien_r;
    first_key_error_flag_ev   = 1'b0;
    second_key_error_flag_ev   = 1'b0;
    good_seq  = 1'b0;
    exp_ev    = 1'b0;
    iclr      = 3'b000;
    wr_mapped = 1'b1;
    if (do_wr) begin
      case (aw_addr_r)
        fdt_pkg::OFF_CTRL: begin
          if (w_strb_r[1]) begin
            on_nxt = w_data_r[fdt_pkg::CTRL_ON_BIT];
          end
        end
        fdt_pkg::OFF_FIRST_KEY: begin
          if (w_strb_r[1]) begin
            first_nxt = w_data_r[15:8];
            first_key_error_flag_ev   = (w_data_r[15:8] != fdt_pkg::FIRST_KEY_OK); // RULE_04
          end
        end
        fdt_pkg::OFF_SECOND_KEY: begin
          if (w_strb_r[0]) begin
            if (w_data_r[7:0] == fdt_pkg::SECOND_KEY_OK &&
                first_r == fdt_pkg::FIRST_KEY_OK) begin
              good_seq = 1'b1;                                // RULE_05
            end else begin
              second_nxt = w_data_r[7:0];                     // RULE_06
              second_key_error_flag_ev    = 1'b1;                              // RULE_06
            end
          end
        end
        fdt_pkg::OFF_IRQ_CLR: begin
          iclr = w_data_r[2:0];
        end
        fdt_pkg::OFF_IRQ_EN: begin
          ien_nxt = w_data_r[2:0];
        end
        fdt_pkg::OFF_STATUS, fdt_pkg::OFF_CNT_LOW, fdt_pkg::OFF_CNT_HIGH,
        fdt_pkg::OFF_CFG_LOW, fdt_pkg::OFF_CFG_HIGH, fdt_pkg::OFF_SNAPSHOT,
        fdt_pkg::OFF_IRQ_STAT: begin
          wr_mapped = 1'b1;  // read-only, write ignored
        end
        default: begin
          wr_mapped = 1'b0;
        end
      endcase
    end
    // a good sequence empties both key fields
    if (good_seq) begin
      first_nxt  = 8'h00;                                     // RULE_07
      second_nxt = 8'h00;                                     // RULE_07
    end
    // counter: restart, step on fetch, freeze at match or after event
    if (good_seq && !flags_r.event_f) begin
      cnt_nxt = fdt_pkg::WORD_ZERO;                           // RULE_05
    end else if (active && !flags_r.event_f) begin
      if (matched) begin
        exp_ev = 1'b1;                                        // RULE_09
      end else if (FETCH_I) begin
        cnt_nxt = cnt_r + fdt_pkg::COUNT_ONE;                 // RULE_01
      end
    end
    // flags only ever set here; only reset clears them
    flags_nxt.first_key_error_flag    = flags_r.first_key_error_flag | first_key_error_flag_ev;               // RULE_10
    flags_nxt.second_key_error_flag    = flags_r.second_key_error_flag | second_key_error_flag_ev;               // RULE_10
    flags_nxt.event_f = flags_r.event_f | exp_ev
                        | (active & (first_key_error_flag_ev | second_key_error_flag_ev));     // RULE_09
  end

  // sticky interrupt status; a new event beats a clear in the same cycle
  always_comb begin
    iev = 3'b000;
    iev[fdt_pkg::IRQ_EVENT_BIT] = flags_nxt.event_f & ~flags_r.event_f;
    iev[fdt_pkg::IRQ_FIRST_KEY_ERROR_FLAG_BIT]  = first_key_error_flag_ev;
    iev[fdt_pkg::IRQ_SECOND_KEY_ERROR_FLAG_BIT]  = second_key_error_flag_ev;
    for (int i = 0; i < fdt_pkg::IRQ_W; i++) begin
      ist_nxt[i] = (ist_r[i] & ~iclr[i]) | iev[i];
    end
    irq_nxt = |(ist_nxt & ien_nxt);
  end

  // AXI4-Lite handshakes: address and data taken in either order
  always_comb begin
    aw_full_nxt = aw_full_r;
    aw_addr_nxt = aw_addr_r;
    w_full_nxt  = w_full_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (AWVALID_I && awready_r) begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = AWADDR_I;
    end
    if (WVALID_I && wready_r) begin
      w_full_nxt = 1'b1;
      w_data_nxt = WDATA_I;
      w_strb_nxt = WSTRB_I;
    end
    if (do_wr) begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_mapped ? fdt_pkg::RESP_OKAY : fdt_pkg::RESP_SLVERR;
    end else if (bvalid_r && BREADY_I) begin
      bvalid_nxt = 1'b0;
    end
    // one write at a time: no new beats until the response is gone
    awready_nxt = ~aw_full_nxt & ~bvalid_nxt & ~do_wr;
    wready_nxt  = ~w_full_nxt & ~bvalid_nxt & ~do_wr;
  end

  // read path; reading either count half loads the snapshot
  always_comb begin
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    snap_nxt    = snap_r;
    if (do_rd) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = fdt_pkg::RESP_OKAY;
      rdata_nxt   = fdt_pkg::WORD_ZERO;
      case (ARADDR_I)
        fdt_pkg::OFF_CTRL: begin
          rdata_nxt[fdt_pkg::CTRL_ON_BIT] = on_r;
        end
        fdt_pkg::OFF_FIRST_KEY: begin
          rdata_nxt[15:8] = first_r;
        end
        fdt_pkg::OFF_SECOND_KEY: begin
          rdata_nxt[7:0] = second_r;
        end
        fdt_pkg::OFF_STATUS: begin
          rdata_nxt[fdt_pkg::ST_FIRST_KEY_ERROR_FLAG_BIT]   = flags_r.first_key_error_flag;
          rdata_nxt[fdt_pkg::ST_SECOND_KEY_ERROR_FLAG_BIT]   = flags_r.second_key_error_flag;
          rdata_nxt[fdt_pkg::ST_EVENT_BIT]  = flags_r.event_f;
          rdata_nxt[fdt_pkg::ST_WINDOW_BIT] = window;         // RULE_08
        end
        fdt_pkg::OFF_CNT_LOW: begin
          rdata_nxt[15:0] = cnt_r[15:0];                      // RULE_12
          snap_nxt        = cnt_r[31:16];                     // RULE_14
        end
        fdt_pkg::OFF_CNT_HIGH: begin
          rdata_nxt[15:0] = cnt_r[31:16];                     // RULE_12
          snap_nxt        = cnt_r[31:16];                     // RULE_14
        end
        fdt_pkg::OFF_CFG_LOW: begin
          rdata_nxt[15:0] = FUSE_I.count_low;                 // RULE_13
        end
        fdt_pkg::OFF_CFG_HIGH: begin
          rdata_nxt[15:0] = FUSE_I.count_high;                // RULE_15
        end
        fdt_pkg::OFF_SNAPSHOT: begin
          rdata_nxt[15:0] = snap_r;
        end
        fdt_pkg::OFF_IRQ_STAT: begin
          rdata_nxt[2:0] = ist_r;
        end
        fdt_pkg::OFF_IRQ_EN: begin
          rdata_nxt[2:0] = ien_r;
        end
        fdt_pkg::OFF_IRQ_CLR: begin
          rdata_nxt = fdt_pkg::WORD_ZERO;  // write-only
        end
        default: begin
          rresp_nxt = fdt_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && RREADY_I) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  // all state registered here, synchronous reset
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_full_r  <= 1'b0;
      w_data_r  <= fdt_pkg::WORD_ZERO;
      w_strb_r  <= 4'h0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= fdt_pkg::RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= fdt_pkg::WORD_ZERO;
      rresp_r   <= fdt_pkg::RESP_OKAY;
      on_r      <= 1'b0;
      first_r   <= 8'h00;
      second_r  <= 8'h00;
      cnt_r     <= fdt_pkg::WORD_ZERO;                        // RULE_12
      snap_r    <= fdt_pkg::HALF_ZERO;                        // RULE_14
      flags_r   <= '0;                                        // RULE_10
      ist_r     <= 3'b000;
      ien_r     <= 3'b000;
      irq_r     <= 1'b0;
    end else begin
      aw_full_r <= aw_full_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_full_r  <= w_full_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      // ready after reset comes one edge late, harmless for a master
      arready_r <= arready_nxt | (~arready_r & ~rvalid_r);
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      on_r      <= on_nxt;
      first_r   <= first_nxt;
      second_r  <= second_nxt;
      cnt_r     <= cnt_nxt;
      snap_r    <= snap_nxt;
      flags_r   <= flags_nxt;
      ist_r     <= ist_nxt;
      ien_r     <= ien_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // outputs straight from flops
  assign AWREADY_O     = awready_r;
  assign WREADY_O      = wready_r;
  assign BVALID_O      = bvalid_r;
  assign BRESP_O       = bresp_r;
  assign ARREADY_O     = arready_r;
  assign RVALID_O      = rvalid_r;
  assign RDATA_O       = rdata_r;
  assign RRESP_O       = rresp_r;
  assign IRQ_O         = irq_r;
  // event line stays up until reset               
  assign DEADMAN_IRQ_O = flags_r.event_f;                     // RULE_11 RULE_16

endmodule

// *** verification/fdt_top_asserts.sv ***
`timescale 1ns/1ps
module fdt_chk (
  // clock, reset, core
  input wire logic               SYS_CLK_I,
  input wire logic               SYS_RST_I,
  input wire logic               FETCH_I,
  input wire logic               DEADMAN_IRQ_O,
  input wire fdt_pkg::fdt_fuse_t FUSE_I,
  // register bus
  input wire logic [7:0]         AWADDR_I,
  input wire logic               AWVALID_I,
  input wire logic               AWREADY_O,
  input wire logic [31:0]        WDATA_I,
  input wire logic [3:0]         WSTRB_I,
  input wire logic               WVALID_I,
  input wire logic               WREADY_O,
  input wire logic [1:0]         BRESP_O,
  input wire logic               BVALID_O,
  input wire logic               BREADY_I,
  input wire logic [7:0]         ARADDR_I,
  input wire logic               ARVALID_I,
  input wire logic               ARREADY_O,
  input wire logic [31:0]        RDATA_O,
  input wire logic [1:0]         RRESP_O,
  input wire logic               RVALID_O,
  input wire logic               RREADY_I,
  input wire logic               IRQ_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // address beat taken this cycle
  wire ar_t = ARVALID_I && ARREADY_O;
  property p_evt_hold; DEADMAN_IRQ_O |=> DEADMAN_IRQ_O; endproperty
  a_evt_hold: assert property (p_evt_hold)
    else $error("deadman irq dropped");
  property p_cfg_lo; ar_t && ARADDR_I == fdt_pkg::OFF_CFG_LOW
    |=> RVALID_O && RDATA_O == {16'h0000, FUSE_I.count_low}; endproperty
  a_cfg_lo: assert property (p_cfg_lo)
    else $error("low mirror wrong");
  property p_cfg_hi; ar_t && ARADDR_I == fdt_pkg::OFF_CFG_HIGH
    |=> RVALID_O && RDATA_O == {16'h0000, FUSE_I.count_high}; endproperty
  a_cfg_hi: assert property (p_cfg_hi)
    else $error("high mirror wrong");
  property p_cnt_w; ar_t && ARADDR_I == fdt_pkg::OFF_CNT_LOW
    |=> RDATA_O[31:16] == 16'h0000; endproperty
  a_cnt_w: assert property (p_cnt_w)
    else $error("count half too wide");
  // fuse-disabled timer can never fire
  property p_off; !FUSE_I.force_on && FUSE_I.timer_disable
    && !DEADMAN_IRQ_O |=> !DEADMAN_IRQ_O; endproperty
  a_off: assert property (p_off)
    else $error("disabled timer fired");
  property p_ar_ans; ar_t |=> RVALID_O && !ARREADY_O; endproperty
  a_ar_ans: assert property (p_ar_ans) else $error("read not answered");
  property p_b_ans; AWVALID_I && AWREADY_O && WVALID_I && WREADY_O
    |-> ##[1:2] BVALID_O; endproperty
  a_b_ans: assert property (p_b_ans) else $error("write not answered");
  property p_unm; ar_t && ARADDR_I == 8'h40 |=> RVALID_O
    && RRESP_O == fdt_pkg::RESP_SLVERR && RDATA_O == 32'h0000_0000;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read accepted");
  c_evt: cover property ($rose(DEADMAN_IRQ_O));
  c_irq: cover property ($rose(IRQ_O));
  c_err: cover property (RVALID_O && RRESP_O == fdt_pkg::RESP_SLVERR);
endmodule
bind fdt_top fdt_chk u_chk (.*);

// *** verification/fdt_core_model.sv ***
`timescale 1ns/1ps
module fdt_core_model (
  // clock and bench control
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic       clr_i,
  // fetch strobe and its tally
  output logic            fetch_o,
  output logic [31:0]     n_o
);
  integer seed = 32'h971c_20f7;
  initial fetch_o = 1'b0;
  initial n_o = 32'h0000_0000;
  // irregular fetches: bursts mixed with sleep gaps
  always @(posedge clk_i) begin
    fetch_o <= run_i && (($random(seed) & 3) != 0);
    n_o <= clr_i ? 32'h0000_0000 : n_o + fetch_o;
  end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic SYS_CLK_I = 0, SYS_RST_I = 1;
  logic FETCH_I, DEADMAN_IRQ_O, AWREADY_O, WREADY_O, BVALID_O;
  logic ARREADY_O, RVALID_O, IRQ_O;
  logic AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0;
  logic ARVALID_I = 0, RREADY_I = 0, run = 0, clr = 0;
  logic [7:0] AWADDR_I = 0, ARADDR_I = 0, k;
  logic [31:0] WDATA_I = 0, RDATA_O, nf, rv, m;
  logic [3:0] WSTRB_I = 0;
  logic [1:0] BRESP_O, RRESP_O, rs;
  fdt_pkg::fdt_fuse_t FUSE_I = '0;
  int failures = 0, total_checks = 0;
  integer seed = 32'h971c_20f7;
  always #20 SYS_CLK_I = ~SYS_CLK_I;
  fdt_top dut (.*);
  fdt_core_model core (.clk_i(SYS_CLK_I), .run_i(run), .clr_i(clr),
    .fetch_o(FETCH_I), .n_o(nf));
  task chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task rst(input logic [33:0] f);
    SYS_RST_I <= 1;
    FUSE_I <= f;
    repeat (10) @(posedge SYS_CLK_I);
    SYS_RST_I <= 0;
  endtask
  // each beat released as soon as it is taken; handshakes are judged
  // on settled values half a cycle ahead, so no race with the edge
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic awt, wt, bt;
    @(posedge SYS_CLK_I);
    AWADDR_I <= a;
    WDATA_I <= d;
    WSTRB_I <= s;
    AWVALID_I <= 1;
    WVALID_I <= 1;
    BREADY_I <= 1;
    do begin
      @(negedge SYS_CLK_I);
      awt = AWVALID_I && AWREADY_O;
      wt = WVALID_I && WREADY_O;
      bt = BVALID_O;
      @(posedge SYS_CLK_I);
      if (awt) AWVALID_I <= 0;
      if (wt) WVALID_I <= 0;
    end while (!bt);
    BREADY_I <= 0;
  endtask
  task rd(input logic [7:0] a);
    logic art, rt;
    @(posedge SYS_CLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1;
    RREADY_I <= 1;
    do begin
      @(negedge SYS_CLK_I);
      art = ARVALID_I && ARREADY_O;
      rt = RVALID_O;
      rv = RDATA_O;
      rs = RRESP_O;
      @(posedge SYS_CLK_I);
      if (art) ARVALID_I <= 0;
    end while (!rt);
    RREADY_I <= 0;
  endtask
  task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, rv, e);
  endtask
  // fresh tally, then let the core fetch for n+1 cycles
  task go(input int n);
    clr <= 1;
    run <= 1;
    @(posedge SYS_CLK_I);
    clr <= 0;
    repeat (n) @(posedge SYS_CLK_I);
    run <= 0;
    repeat (4) @(posedge SYS_CLK_I);
  endtask
  function logic [31:0] st(input logic b1, b2, ev, w);
    return {24'h00_0000, b1, b2, ev, 4'h0, w};
  endfunction
  function logic [31:0] cnt();
    return (nf < m) ? nf : m;
  endfunction
  initial begin
    repeat (20000) @(posedge SYS_CLK_I);
    failures++;
    $display("watchdog expired");
    end_sim();
  end
  initial begin
    m = 32'h0000_0008 + ($random(seed) & 32'h0000_000F);
    rst({2'b00, 16'h0000, m[15:0]});
    // reset table: nine registers that read zero after reset, both config mirrors and IRQ enable left out
    for (int i = 0; i < 9; i++)
      rc("reset value", 8'(4 * (i < 6 ? i : i + 2)), 0);
    rc("cfg low", fdt_pkg::OFF_CFG_LOW, {16'h0000, m[15:0]});
    rd(8'h40);
    chk("unmapped resp", rs, fdt_pkg::RESP_SLVERR);
    go(6);
    rc("count off", fdt_pkg::OFF_CNT_LOW, 0);
    wr(fdt_pkg::OFF_CTRL, 32'h0000_8000, 4'b0010);
    go(6);
    rc("count", fdt_pkg::OFF_CNT_LOW, nf);
    rc("count high", fdt_pkg::OFF_CNT_HIGH, 0);
    rc("snapshot", fdt_pkg::OFF_SNAPSHOT, 0);
    wr(fdt_pkg::OFF_FIRST_KEY, 32'h0000_4000, 4'b0010);
    rc("window", fdt_pkg::OFF_STATUS, st(0, 0, 0, 1));
    rc("first key", fdt_pkg::OFF_FIRST_KEY, 32'h0000_4000);
    wr(fdt_pkg::OFF_SECOND_KEY, 32'h0000_0008, 4'b0001);
    rc("first clr", fdt_pkg::OFF_FIRST_KEY, 0);
    rc("second clr", fdt_pkg::OFF_SECOND_KEY, 0);
    rc("restart", fdt_pkg::OFF_CNT_LOW, 0);
    rc("closed", fdt_pkg::OFF_STATUS, 0);
    $display("test keys done");
    go(4 * m + 20);
    rc("stop", fdt_pkg::OFF_CNT_LOW, cnt());
    rc("expired", fdt_pkg::OFF_STATUS, st(0, 0, 1, 0));
    chk("deadman irq", DEADMAN_IRQ_O, 1);
    rc("irq stat", fdt_pkg::OFF_IRQ_STAT, 1);
    chk("irq masked", IRQ_O, 0);
    wr(fdt_pkg::OFF_IRQ_EN, 32'h0000_0001, 4'b0001);
    chk("irq on", IRQ_O, 1);
    wr(fdt_pkg::OFF_IRQ_CLR, 32'h0000_0001, 4'b0001);
    chk("irq off", IRQ_O, 0);
    rc("irq clr", fdt_pkg::OFF_IRQ_STAT, 0);
    wr(fdt_pkg::OFF_FIRST_KEY, 32'h0000_4000, 4'b0010);
    wr(fdt_pkg::OFF_SECOND_KEY, 32'h0000_0008, 4'b0001);
    rc("sticky", fdt_pkg::OFF_STATUS, st(0, 0, 1, 0));
    rc("held", fdt_pkg::OFF_CNT_LOW, m);
    chk("irq held", DEADMAN_IRQ_O, 1);
    $display("test expiry done");
    rst({2'b10, 16'h0000, m[15:0]});
    go(6);
    rc("fuse on", fdt_pkg::OFF_CNT_LOW, nf);
    k = $random(seed);
    if (k == 8'h40) k = 8'h41;
    wr(fdt_pkg::OFF_FIRST_KEY, {16'h0000, k, 8'h00}, 4'b0010);
    rc("bad first", fdt_pkg::OFF_STATUS, st(1, 0, 1, 0));
    chk("bad irq", DEADMAN_IRQ_O, 1);
    rst({2'b10, 16'h0000, m[15:0]});
    k = $random(seed);
    if (k == 8'h08) k = 8'h09;
    wr(fdt_pkg::OFF_FIRST_KEY, 32'h0000_4000, 4'b0010);
    wr(fdt_pkg::OFF_SECOND_KEY, {24'h00_0000, k}, 4'b0001);
    rc("bad second", fdt_pkg::OFF_STATUS, st(0, 1, 1, 0));
    rc("kept", fdt_pkg::OFF_FIRST_KEY, 32'h0000_4000);
    rc("captured", fdt_pkg::OFF_SECOND_KEY, {24'h00_0000, k});
    $display("test bad keys done");
    m[31:16] = 16'($random(seed));
    rst({2'b01, m[31:16], m[15:0]});
    wr(fdt_pkg::OFF_CTRL, 32'h0000_8000, 4'b0010);
    go(10);
    rc("fuse off", fdt_pkg::OFF_CNT_LOW, 0);
    rc("cfg high", fdt_pkg::OFF_CFG_HIGH, {16'h0000, m[31:16]});
    $display("test fuse done");
    end_sim();
  end
endmodule
